/* include/urt_cfg.svh */
`ifndef URT_CFG_SVH
`define URT_CFG_SVH

`define URT_WORD_W 8
`define URT_DIV_W 16
`define URT_FIFO_DEPTH 4
`define URT_OVS_LAST 4'hF
`define URT_OVS_MID 4'h7
`define URT_BIT_LAST 3'h7
`define URT_DIV_RST 16'h0001
`define URT_LSR_DR 0
`define URT_LSR_THRE 5
`define URT_LSR_TEMT 6

`endif

/* include/urt_pkg.sv */
package urt_pkg;

  typedef enum logic [3:0] {
    URT_IDLE  = 4'h1,
    URT_START = 4'h2,
    URT_DATA  = 4'h4,
    URT_STOP  = 4'h8
  } urt_ser_st_t;

endpackage

/* rtl/urt_fifo.sv */
`timescale 1ns/1ps
module urt_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign o_ready = (cnt_q != FULL);
  assign o_valid = (cnt_q != '0);
  assign o_data = mem_q[rd_q];
  assign push = i_valid & o_ready;
  assign pop = o_valid & i_ready;

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_ent
      always_ff @(posedge i_ref_clk) begin
        if (push && wr_q == AW'(g)) begin
          mem_q[g] <= i_data;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == LAST) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == LAST) ? '0 : rd_q + 1'b1;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= '0;
    end else if (push && !pop) begin
      cnt_q <= cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule

/* rtl/urt_chan.sv */
// Contract
// (RULE1) Receive-ready rises at most one clock after the stop bit is sampled.
// (RULE2) Transmit-ready falls within sixteen baud ticks of the start bit beginning. FIFO mode drops it only when the transmit FIFO is full.
// (RULE3) Host spaces successive write and read strobes by at least four periods.
// (RULE4) Single-byte mode: holding data valid one baud tick after status reports it.
// (RULE5) Internal baud tick runs at sixteen times the bit rate.
// (RULE6) FIFO mode: holding data valid as soon as status reports it.
// (RULE7) Single-byte mode: host waits one baud tick after status before reading.
`timescale 1ns/1ps
`include "urt_cfg.svh"
module urt_chan import urt_pkg::*; #(
  parameter int DIV_W = `URT_DIV_W,
  parameter int FIFO_DEPTH = `URT_FIFO_DEPTH
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic [DIV_W-1:0] i_divisor,
  input wire logic i_fifo_mode,
  input wire logic i_rxd,
  output logic o_txd,
  input wire logic i_host_write_strobe,
  input wire logic [`URT_WORD_W-1:0] i_wdata,
  input wire logic i_host_read_strobe,
  output logic [`URT_WORD_W-1:0] o_rdata,
  output logic [`URT_WORD_W-1:0] o_line_status_reg,
  output logic o_rx_ready_pin,
  output logic o_tx_ready_pin
);
  logic [DIV_W-1:0] div_q;
  logic tick;
  urt_ser_st_t rx_st_q;
  logic [3:0] rx_os_q;
  logic [2:0] rx_bit_q;
  logic [`URT_WORD_W-1:0] rx_sh_q;
  logic stop_evt;
  logic avail_q;
  logic pend_q;
  logic [`URT_WORD_W-1:0] receive_holding_reg_q;
  logic [`URT_WORD_W-1:0] rdata_q;
  urt_ser_st_t tx_st_q;
  logic [3:0] tx_os_q;
  logic [2:0] tx_bit_q;
  logic [`URT_WORD_W-1:0] tx_sh_q;
  logic txd_q;
  logic tx_start;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [`URT_WORD_W-1:0] fifo_out_data;
  logic tx_idle;

  // Divider gives the oversampling enable; divisor 0 acts as 1
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_q <= '0;
    end else if (div_q == '0) begin
      div_q <= (i_divisor == '0) ? '0 : i_divisor - 1'b1; // RULE5
    end else begin
      div_q <= div_q - 1'b1;
    end
  end
  assign tick = (div_q == '0); // RULE5

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_st_q <= URT_IDLE;
      rx_os_q <= '0;
      rx_bit_q <= '0;
      rx_sh_q <= '0;
    end else if (tick) begin
      unique case (rx_st_q)
        URT_IDLE: begin
          rx_os_q <= '0;
          if (!i_rxd) begin
            rx_st_q <= URT_START;
          end
        end
        URT_START: begin
          rx_os_q <= rx_os_q + 1'b1;
          if (rx_os_q == `URT_OVS_MID) begin
            // A high line at mid start bit is a false start
            rx_st_q <= i_rxd ? URT_IDLE : URT_DATA;
            rx_os_q <= '0;
            rx_bit_q <= '0;
          end
        end
        URT_DATA: begin
          rx_os_q <= rx_os_q + 1'b1; // RULE5
          if (rx_os_q == `URT_OVS_LAST) begin
            rx_sh_q <= {i_rxd, rx_sh_q[`URT_WORD_W-1:1]};
            rx_bit_q <= rx_bit_q + 1'b1;
            if (rx_bit_q == `URT_BIT_LAST) begin
              rx_st_q <= URT_STOP;
            end
          end
        end
        URT_STOP: begin
          rx_os_q <= rx_os_q + 1'b1;
          if (rx_os_q == `URT_OVS_LAST) begin
            rx_st_q <= URT_IDLE;
          end
        end
        default: begin
          rx_st_q <= URT_IDLE;
        end
      endcase
    end
  end
  assign stop_evt = tick && rx_st_q == URT_STOP && rx_os_q == `URT_OVS_LAST;

  // Data-ready status; a new character beats a simultaneous read
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      avail_q <= 1'b0;
    end else if (stop_evt) begin
      avail_q <= 1'b1; // RULE1
    end else if (i_host_read_strobe) begin
      avail_q <= 1'b0;
    end
  end
  assign o_rx_ready_pin = avail_q; // RULE1

  // Single-byte mode loads the holding register one tick late
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pend_q <= 1'b0;
      receive_holding_reg_q <= '0;
    end else if (stop_evt && i_fifo_mode) begin
      receive_holding_reg_q <= rx_sh_q; // RULE6
      pend_q <= 1'b0;
    end else if (stop_evt) begin
      pend_q <= 1'b1; // RULE4
    end else if (pend_q && tick) begin
      receive_holding_reg_q <= rx_sh_q; // RULE4
      pend_q <= 1'b0;
    end
  end

  // Early reads in single-byte mode return the previous character
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q <= '0;
    end else if (i_host_read_strobe) begin
      rdata_q <= receive_holding_reg_q; // RULE7
    end
  end
  assign o_rdata = rdata_q;

  urt_fifo #(
    .WIDTH(`URT_WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_valid(i_host_write_strobe && o_tx_ready_pin),
    .o_ready(fifo_in_ready),
    .i_data(i_wdata),
    .o_valid(fifo_out_valid),
    .i_ready(tx_start),
    .o_data(fifo_out_data)
  );

  assign tx_idle = (tx_st_q == URT_IDLE);
  assign tx_start = tick && tx_idle && fifo_out_valid;
  // Single-byte mode accepts only when holding and shift stages are empty
  assign o_tx_ready_pin = i_fifo_mode ? fifo_in_ready : (!fifo_out_valid && tx_idle); // RULE2

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_st_q <= URT_IDLE;
      tx_os_q <= '0;
      tx_bit_q <= '0;
      tx_sh_q <= '0;
    end else if (tick) begin
      unique case (tx_st_q)
        URT_IDLE: begin
          tx_os_q <= '0;
          tx_bit_q <= '0;
          if (fifo_out_valid) begin
            tx_sh_q <= fifo_out_data;
            tx_st_q <= URT_START;
          end
        end
        URT_START: begin
          tx_os_q <= tx_os_q + 1'b1;
          if (tx_os_q == `URT_OVS_LAST) begin
            tx_st_q <= URT_DATA;
          end
        end
        URT_DATA: begin
          tx_os_q <= tx_os_q + 1'b1;
          if (tx_os_q == `URT_OVS_LAST) begin
            tx_sh_q <= {1'b0, tx_sh_q[`URT_WORD_W-1:1]};
            tx_bit_q <= tx_bit_q + 1'b1;
            if (tx_bit_q == `URT_BIT_LAST) begin
              tx_st_q <= URT_STOP;
            end
          end
        end
        URT_STOP: begin
          tx_os_q <= tx_os_q + 1'b1;
          if (tx_os_q == `URT_OVS_LAST) begin
            tx_st_q <= URT_IDLE;
          end
        end
        default: begin
          tx_st_q <= URT_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      txd_q <= 1'b1;
    end else begin
      txd_q <= (tx_st_q == URT_START) ? 1'b0 : (tx_st_q == URT_DATA) ? tx_sh_q[0] : 1'b1;
    end
  end
  assign o_txd = txd_q;

  always_comb begin
    o_line_status_reg = '0;
    o_line_status_reg[`URT_LSR_DR] = avail_q;
    o_line_status_reg[`URT_LSR_THRE] = !fifo_out_valid;
    o_line_status_reg[`URT_LSR_TEMT] = !fifo_out_valid && tx_idle;
  end

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);

  a_rx_ready_set: // RULE1
    assert property (stop_evt |=> o_rx_ready_pin && o_line_status_reg[`URT_LSR_DR])
      else $error("receive ready not raised after stop bit");
  a_tx_ready_drop: // RULE2
    assert property (tx_start && !i_fifo_mode |=> !o_tx_ready_pin [*2])
      else $error("transmit ready high after start bit");
  a_rhr_late: // RULE4
    assert property (stop_evt && !i_fifo_mode |=> pend_q && $stable(receive_holding_reg_q))
      else $error("single-byte holding register pending flag lost");
  a_rhr_load: // RULE4
    assert property (pend_q && tick && !stop_evt |=> !pend_q && receive_holding_reg_q == $past(rx_sh_q))
      else $error("holding register not loaded on the baud tick");
  a_rhr_fifo_now: // RULE6
    assert property (stop_evt && i_fifo_mode |=> receive_holding_reg_q == $past(rx_sh_q) && avail_q)
      else $error("fifo mode holding data not valid with status");
  a_baud_tick_rate: // RULE5
    assert property (tick && i_divisor == 16'h0004 && $stable(i_divisor) |=> !tick ##1 !tick ##1 !tick ##1 tick)
      else $error("baud tick spacing differs from divisor");
  a_bit_sixteen: // RULE5
    assert property ($changed(tx_sh_q) && tx_st_q != URT_START |-> $past(tick) && $past(tx_os_q) == `URT_OVS_LAST)
      else $error("transmit bit shifted off the sixteenth tick");

  c_rx_char: cover property (stop_evt ##1 i_host_read_strobe);
  c_tx_char: cover property (tx_start ##[1:1000] tx_idle);
  c_fifo_full: cover property (i_fifo_mode && !fifo_in_ready);
endmodule

/* verification/urt_host_model.sv */
`timescale 1ns/1ps
module urt_host_model #(
  parameter int DIV = 4
) (
  input wire logic i_ref_clk,
  input wire logic i_fifo_mode,
  input wire logic [7:0] i_rdata,
  output logic o_host_write_strobe,
  output logic o_host_read_strobe,
  output logic [7:0] o_wdata
);
  initial begin
    o_host_write_strobe = 1'b0;
    o_host_read_strobe = 1'b0;
    o_wdata = 8'h00;
  end
  task automatic gap();
    repeat (4) @(posedge i_ref_clk);
    #1;
  endtask
  task automatic write(input logic [7:0] d);
    o_host_write_strobe = 1'b1;
    o_wdata = d;
    @(posedge i_ref_clk);
    #1;
    o_host_write_strobe = 1'b0;
    o_wdata = ~d;
    gap();
  endtask
  // Quick skips the single-byte settle wait to expose stale holding data
  task automatic read(output logic [7:0] d, input logic quick);
    if (!i_fifo_mode && !quick) begin
      repeat (DIV) @(posedge i_ref_clk);
      #1;
    end
    o_host_read_strobe = 1'b1;
    @(posedge i_ref_clk);
    #1;
    o_host_read_strobe = 1'b0;
    d = i_rdata;
    gap();
  endtask
endmodule

/* verification/testbench.sv */
`timescale 1ns/1ps
module testbench;
  localparam int DIV = 4;
  localparam int BIT = 16 * DIV;
  typedef struct packed {logic m; logic [7:0] d;} urt_row_t;
  logic i_ref_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_fifo_mode = 1'b0;
  logic i_rxd = 1'b1;
  logic o_txd, o_rx_ready_pin, o_tx_ready_pin, wr, rd;
  logic [7:0] o_rdata, o_line_status_reg, wd, got;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;
  urt_row_t rows [4] = '{'{1'b1, 8'hA5}, '{1'b0, 8'h3C}, '{1'b1, 8'h00}, '{1'b0, 8'hFF}};

  urt_chan u_dut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_divisor(16'h0004), .i_fifo_mode(i_fifo_mode),
    .i_rxd(i_rxd), .o_txd(o_txd), .i_host_write_strobe(wr), .i_wdata(wd), .i_host_read_strobe(rd),
    .o_rdata(o_rdata), .o_line_status_reg(o_line_status_reg), .o_rx_ready_pin(o_rx_ready_pin),
    .o_tx_ready_pin(o_tx_ready_pin));
  urt_host_model #(.DIV(DIV)) u_host (.i_ref_clk(i_ref_clk), .i_fifo_mode(i_fifo_mode), .i_rdata(o_rdata),
    .o_host_write_strobe(wr), .o_host_read_strobe(rd), .o_wdata(wd));

  always #2 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      final_report();
    end
  end

  task automatic final_report();
    if (error_cnt == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Drives start and data bits, then the stop bit; returns just after receive-ready rises
  task automatic send_rx(input logic [7:0] d);
    logic [8:0] f;
    int n;
    f = {d, 1'b0};
    for (int i = 0; i < 9; i++) begin
      i_rxd = f[i];
      repeat (BIT) @(posedge i_ref_clk);
      #1;
    end
    i_rxd = 1'b1;
    check(o_rx_ready_pin, 1'b0);
    n = 0;
    while (o_rx_ready_pin !== 1'b1 && n < BIT / 2 + DIV + 2) begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end
    check(o_rx_ready_pin, 1'b1);
  endtask
  // Samples each data bit and the stop bit in its middle; returns at the stop bit's middle
  task automatic get_tx(output logic [7:0] d);
    int n;
    n = 0;
    while (o_txd !== 1'b0 && n < 4 * BIT) begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end
    if (!i_fifo_mode) check(o_tx_ready_pin, 1'b0);
    repeat (BIT / 2) @(posedge i_ref_clk);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT) @(posedge i_ref_clk);
      #1;
      if (i < 8) d[i] = o_txd;
    end
    check(o_txd, 1'b1);
  endtask

  initial begin
    repeat (20) @(posedge i_ref_clk);
    #1;
    check(o_line_status_reg, 8'h60);
    check(o_rdata, 8'h00);
    check({o_txd, o_rx_ready_pin, o_tx_ready_pin}, 8'h05);
    i_rst_n = 1'b1;
    foreach (rows[r]) begin
      i_fifo_mode = rows[r].m;
      fork
        send_rx(rows[r].d);
        u_host.write(~rows[r].d);
        get_tx(got);
      join
      check(got, ~rows[r].d);
      repeat (BIT / 2 + 2) @(posedge i_ref_clk);
      #1;
      check(o_tx_ready_pin, 1'b1);
      u_host.read(got, 1'b0);
      check(got, rows[r].d);
      check(o_rx_ready_pin, 1'b0);
    end
    // Early read in single-byte mode still returns the previous character
    send_rx(8'h5A);
    check(o_line_status_reg[0], 1'b1);
    u_host.read(got, 1'b1);
    check(got, 8'hFF);
    u_host.read(got, 1'b0);
    check(got, 8'h5A);
    // FIFO mode has the new character in place as soon as ready rises
    i_fifo_mode = 1'b1;
    send_rx(8'hC3);
    u_host.read(got, 1'b1);
    check(got, 8'hC3);
    // Fill the transmit buffer until it refuses, then drain it
    i_fifo_mode = 1'b1;
    fork
      begin
        for (int k = 0; k < 5; k++) u_host.write({4'h1, 4'(k)});
        check(o_tx_ready_pin, 1'b0);
        u_host.write(8'hEE);
      end
      for (int k = 0; k < 5; k++) begin
        get_tx(got);
        check(got, {4'h1, 4'(k)});
      end
    join
    repeat (BIT / 2 + 2) @(posedge i_ref_clk);
    #1;
    check(o_line_status_reg, 8'h60);
    // Reset in mid-run with a character waiting clears ready and read data
    send_rx(8'h81);
    i_rst_n = 1'b0;
    @(posedge i_ref_clk);
    #1;
    check(o_rdata, 8'h00);
    check({o_txd, o_rx_ready_pin, o_tx_ready_pin}, 8'h05);
    i_rst_n = 1'b1;
    repeat (2) @(posedge i_ref_clk);
    #1;
    check(o_line_status_reg, 8'h60);
    check({o_txd, o_rx_ready_pin, o_tx_ready_pin}, 8'h05);
    final_report();
  end
endmodule
